// file: src/ifb_pkg.sv
// ifb_pkg: register map, field positions and reset values for the
// interrupt flag and enable bank.
// assumes a 32-bit apb with word-aligned registers.
package ifb_pkg;

   // =====================================================================
   // register byte offsets
   localparam logic [11:0] OFF_FLAG_STATUS_FIVE    = 12'h000;
   localparam logic [11:0] OFF_FLAG_STATUS_SIX     = 12'h004;
   localparam logic [11:0] OFF_FLAG_STATUS_SEVEN   = 12'h008;
   localparam logic [11:0] OFF_ENABLE_CONTROL_ZERO = 12'h00c;
   localparam logic [11:0] OFF_REQUEST_STATUS      = 12'h010;

   // =====================================================================
   // implemented-bit masks and reset values
   localparam logic [15:0] MASK_FIVE  = 16'hc000;
   localparam logic [15:0] MASK_SIX   = 16'hc383;
   localparam logic [15:0] MASK_SEVEN = 16'h001f;
   localparam logic [15:0] MASK_EN0   = 16'h3fef;
   localparam logic [15:0] RST_REG    = 16'h0000;

   // =====================================================================
   // flag register five fields
   localparam int POS_PWM_GEN2_FLAG = 15;
   localparam int POS_PWM_GEN1_FLAG = 14;
   // flag register six fields
   localparam int POS_ADC_PAIR1_DONE_FLAG = 15;
   localparam int POS_ADC_PAIR0_DONE_FLAG = 14;
   localparam int POS_COMPARATOR4_FLAG    = 9;
   localparam int POS_COMPARATOR3_FLAG    = 8;
   localparam int POS_COMPARATOR2_FLAG    = 7;
   localparam int POS_PWM_GEN4_FLAG       = 1;
   localparam int POS_PWM_GEN3_FLAG       = 0;
   // flag register seven: adc pairs 6..2 at bits 4..0
   localparam int POS_ADC_PAIR2_DONE_FLAG = 0;
   // enable register zero fields
   localparam int POS_ADC_COMPLETE_ENABLE  = 13;
   localparam int POS_UART_TX_ENABLE_BIT   = 12;
   localparam int POS_UART_RX_ENABLE_BIT   = 11;
   localparam int POS_SPI_EVENT_ENABLE_BIT = 10;
   localparam int POS_SPI_SECOND_ENABLE_BIT = 9;
   localparam int POS_TIMER3_ENABLE_BIT    = 8;
   localparam int POS_TIMER2_ENABLE_BIT    = 7;
   localparam int POS_COMPARE2_ENABLE_BIT  = 6;
   localparam int POS_CAPTURE2_ENABLE_BIT  = 5;
   localparam int POS_TIMER1_ENABLE_BIT    = 3;
   localparam int POS_COMPARE1_ENABLE_BIT  = 2;
   localparam int POS_CAPTURE1_ENABLE_BIT  = 1;
   localparam int POS_EXT_IRQ0_ENABLE_BIT  = 0;

endpackage

// file: src/ifb_bank.sv
// ifb_bank: three interrupt flag status registers and enable register
// zero behind an apb slave, with the flag-and-enable request output.
// assumes event pulses synchronous to pclk; the group-zero flags that
// the enables gate arrive as a 16-bit level vector from outside.
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/1ps

module ifb_bank
   import ifb_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [15:0] set_five,
   input  wire logic [15:0] set_six,
   input  wire logic [15:0] set_seven,
   input  wire logic [15:0] group0_flags,
   output logic      [15:0] request_five,
   output logic      [15:0] request_six,
   output logic      [15:0] request_seven,
   output logic      [15:0] request_zero,
   output logic      [15:0] enable_zero
);

   // =====================================================================
   // state
   logic [15:0] flag_status_five;
   logic [15:0] flag_status_six;
   logic [15:0] flag_status_seven;
   logic [15:0] enable_control_zero;
   logic [15:0] next_five;
   logic [15:0] next_six;
   logic [15:0] next_seven;
   logic [15:0] next_en0;
   logic [31:0] next_prdata;
   logic        next_pready;
   logic        next_pslverr;
   logic [15:0] next_req5;
   logic [15:0] next_req6;
   logic [15:0] next_req7;
   logic [15:0] next_req0;
   logic        wr_acc;
   logic        rd_acc;

   // merge a byte-strobed write into a register, keeping only real bits
   function automatic logic [15:0] wr_merge(input logic [15:0] cur,
                                            input logic [31:0] wd,
                                            input logic [3:0]  st,
                                            input logic [15:0] msk);
      logic [15:0] v;
      v = cur;
      if (st[0]) begin
         v[7:0] = wd[7:0];
      end
      if (st[1]) begin
         v[15:8] = wd[15:8];
      end
      wr_merge = v & msk;
   endfunction

   // every access completes in its first access cycle, so pready is a
   // registered copy of the setup-phase select
   assign wr_acc = psel & penable & pready & pwrite;
   assign rd_acc = psel & ~penable & ~pwrite;

   // =====================================================================
   // flag and enable next values
   always_comb begin
      next_five  = flag_status_five;
      next_six   = flag_status_six;
      next_seven = flag_status_seven;
      next_en0   = enable_control_zero;
      if (wr_acc) begin
         unique case (paddr)
            OFF_FLAG_STATUS_FIVE:
               next_five = wr_merge(next_five, pwdata, pstrb,
                                    MASK_FIVE);
            OFF_FLAG_STATUS_SIX:
               next_six = wr_merge(next_six, pwdata, pstrb,
                                   MASK_SIX);
            OFF_FLAG_STATUS_SEVEN:
               next_seven = wr_merge(next_seven, pwdata, pstrb,
                                     MASK_SEVEN);
            OFF_ENABLE_CONTROL_ZERO:
               next_en0 = wr_merge(next_en0, pwdata, pstrb,
                                   MASK_EN0);
            default: ;
         endcase
      end
      // event set wins over a same-cycle software clear
      next_five  = next_five  | (set_five  & MASK_FIVE);
      next_six   = next_six   | (set_six   & MASK_SIX);
      next_seven = next_seven | (set_seven & MASK_SEVEN);
   end

   // =====================================================================
   // request outputs and bus answer next values
   always_comb begin
      // flag banks 5..7 have their enables elsewhere; pass them pending
      next_req5 = flag_status_five;
      next_req6 = flag_status_six;
      next_req7 = flag_status_seven;
      next_req0 = group0_flags & enable_control_zero;
      next_pready  = psel & ~penable;
      next_pslverr = 1'b0;
      next_prdata  = 32'h0000_0000;
      if (psel & ~penable) begin
         unique case (paddr)
            // upper half always reads zero, registers are 16 bits wide
            OFF_FLAG_STATUS_FIVE:
               next_prdata = {16'h0000, flag_status_five};
            OFF_FLAG_STATUS_SIX:
               next_prdata = {16'h0000, flag_status_six};
            OFF_FLAG_STATUS_SEVEN:
               next_prdata = {16'h0000, flag_status_seven};
            OFF_ENABLE_CONTROL_ZERO:
               next_prdata = {16'h0000, enable_control_zero};
            OFF_REQUEST_STATUS:
               next_prdata = {16'h0000, next_req0};
            default:                 next_pslverr = 1'b1; // unmapped address
         endcase
         if (!rd_acc) begin
            next_prdata = 32'h0000_0000;
         end
      end
   end

   // =====================================================================
   // registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_status_five    <= RST_REG;
         flag_status_six     <= RST_REG;
         flag_status_seven   <= RST_REG;
         enable_control_zero <= RST_REG;
         request_five        <= RST_REG;
         request_six         <= RST_REG;
         request_seven       <= RST_REG;
         request_zero        <= RST_REG;
         enable_zero         <= RST_REG;
         prdata              <= 32'h0000_0000;
         pready              <= 1'b0;
         pslverr             <= 1'b0;
      end else begin
         flag_status_five    <= next_five;
         flag_status_six     <= next_six;
         flag_status_seven   <= next_seven;
         enable_control_zero <= next_en0;
         request_five        <= next_req5;
         request_six         <= next_req6;
         request_seven       <= next_req7;
         request_zero        <= next_req0;
         enable_zero         <= next_en0;
         prdata              <= next_prdata;
         pready              <= next_pready;
         pslverr             <= next_pslverr;
      end
   end

   // =====================================================================
   // assertions
   // apb steps: a setup cycle, then its single access cycle
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable && pready;
   endsequence
   // enable register zero writes, one per byte lane
   sequence s_en0_low_wr;
      wr_acc && paddr == OFF_ENABLE_CONTROL_ZERO && pstrb[0];
   endsequence
   sequence s_en0_high_wr;
      wr_acc && paddr == OFF_ENABLE_CONTROL_ZERO && pstrb[1];
   endsequence

   // unimplemented positions never hold a one
   a_five_low_zero: assert property (
      @(posedge pclk) disable iff (!presetn)
      flag_status_five[13:0] == 14'h0000)
      else $error("flag five low bits not zero");
   a_six_gaps_zero: assert property (
      @(posedge pclk) disable iff (!presetn)
      (flag_status_six & ~MASK_SIX) == 16'h0000)
      else $error("flag six unused bits set");
   a_seven_high_zero: assert property (
      @(posedge pclk) disable iff (!presetn)
      flag_status_seven[15:5] == 11'h000)
      else $error("flag seven high bits set");
   a_en0_gaps_zero: assert property (
      @(posedge pclk) disable iff (!presetn)
      enable_control_zero[15:14] == 2'h0 && !enable_control_zero[4])
      else $error("enable zero unused bits set");
   a_read_top_zero: assert property (
      @(posedge pclk) disable iff (!presetn)
      pready |-> prdata[31:16] == 16'h0000)
      else $error("read data upper half not zero");

   // event pulses land in their own flag positions; flag seven holds with no write or event
   a_pwm_gen2_set: assert property (
      @(posedge pclk) disable iff (!presetn)
      set_five[POS_PWM_GEN2_FLAG] |=> flag_status_five[POS_PWM_GEN2_FLAG])
      else $error("pwm gen2 flag not set");
   a_pwm_gen1_set: assert property (
      @(posedge pclk) disable iff (!presetn)
      set_five[POS_PWM_GEN1_FLAG] |=> flag_status_five[POS_PWM_GEN1_FLAG])
      else $error("pwm gen1 flag not set");
   a_adc_pair1_set: assert property (
      @(posedge pclk) disable iff (!presetn)
      set_six[POS_ADC_PAIR1_DONE_FLAG]
      |=> flag_status_six[POS_ADC_PAIR1_DONE_FLAG])
      else $error("adc pair1 flag not set");
   a_adc_pair0_set: assert property (
      @(posedge pclk) disable iff (!presetn)
      set_six[POS_ADC_PAIR0_DONE_FLAG]
      |=> flag_status_six[POS_ADC_PAIR0_DONE_FLAG])
      else $error("adc pair0 flag not set");
   a_comp4_set: assert property (
      @(posedge pclk) disable iff (!presetn)
      set_six[POS_COMPARATOR4_FLAG] |=> flag_status_six[POS_COMPARATOR4_FLAG])
      else $error("comparator4 flag not set");
   a_comp2_set: assert property (
      @(posedge pclk) disable iff (!presetn)
      set_six[POS_COMPARATOR2_FLAG] |=> flag_status_six[POS_COMPARATOR2_FLAG])
      else $error("comparator2 flag not set");
   a_pwm_gen3_set: assert property (
      @(posedge pclk) disable iff (!presetn)
      set_six[POS_PWM_GEN3_FLAG] |=> flag_status_six[POS_PWM_GEN3_FLAG])
      else $error("pwm gen3 flag not set");
   a_pair2_set: assert property (
      @(posedge pclk) disable iff (!presetn)
      set_seven[POS_ADC_PAIR2_DONE_FLAG]
      |=> flag_status_seven[POS_ADC_PAIR2_DONE_FLAG])
      else $error("adc pair2 flag not set");
   a_flag_holds: assert property (
      @(posedge pclk) disable iff (!presetn)
      !wr_acc && set_seven == 16'h0000 |=> $stable(flag_status_seven))
      else $error("flag seven changed without cause");

   // enable bits follow the byte lane that carries them
   a_ext0_enable: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_en0_low_wr
      |=> enable_control_zero[POS_EXT_IRQ0_ENABLE_BIT]
          == $past(pwdata[POS_EXT_IRQ0_ENABLE_BIT]))
      else $error("ext irq0 enable not written");
   a_adc_enable: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_en0_high_wr
      |=> enable_control_zero[POS_ADC_COMPLETE_ENABLE]
          == $past(pwdata[POS_ADC_COMPLETE_ENABLE]))
      else $error("adc complete enable not written");
   a_spi_enable: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_en0_high_wr
      |=> enable_control_zero[POS_SPI_EVENT_ENABLE_BIT]
          == $past(pwdata[POS_SPI_EVENT_ENABLE_BIT]))
      else $error("spi event enable not written");
   a_timer1_enable: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_en0_low_wr
      |=> enable_control_zero[POS_TIMER1_ENABLE_BIT]
          == $past(pwdata[POS_TIMER1_ENABLE_BIT]))
      else $error("timer1 enable not written");
   a_capture2_enable: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_en0_low_wr
      |=> enable_control_zero[POS_CAPTURE2_ENABLE_BIT]
          == $past(pwdata[POS_CAPTURE2_ENABLE_BIT]))
      else $error("capture2 enable not written");

   // a request passes only through a set enable
   a_request_gate: assert property (
      @(posedge pclk) disable iff (!presetn)
      ##1 request_zero
          == ($past(group0_flags) & $past(enable_control_zero)))
      else $error("request not flag and enable");
   a_ext0_blocked: assert property (
      @(posedge pclk) disable iff (!presetn)
      !enable_control_zero[POS_EXT_IRQ0_ENABLE_BIT]
      |=> !request_zero[POS_EXT_IRQ0_ENABLE_BIT])
      else $error("blocked request passed");

   // every access answers in its first access cycle
   a_one_wait: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_setup |=> s_access)
      else $error("apb answer not in one cycle");

endmodule // ifb_bank

// file: test/ifb_event_src.sv
// ifb_event_src: peripheral event sources that feed the flag bank.
// assumes fire, sel and bits change just after a rising pclk edge.
`timescale 1ns/1ps
module ifb_event_src (
   input  wire logic        pclk,
   input  wire logic        fire,
   input  wire logic [1:0]  sel,
   input  wire logic [15:0] bits,
   output logic      [15:0] set_five,
   output logic      [15:0] set_six,
   output logic      [15:0] set_seven,
   output logic      [15:0] group0_flags
);
   // =====================================================================
   // quiet sources until the bench asks for an event
   initial begin
      set_five     = 16'h0000;
      set_six      = 16'h0000;
      set_seven    = 16'h0000;
      group0_flags = 16'h0000;
   end
   // single-cycle pulses, so a flag that stays set proves it was latched
   always @(posedge pclk) begin
      set_five  <= (fire && sel == 2'd0) ? bits : 16'h0000;
      set_six   <= (fire && sel == 2'd1) ? bits : 16'h0000;
      set_seven <= (fire && sel == 2'd2) ? bits : 16'h0000;
      if (fire && sel == 2'd3) begin
         group0_flags <= bits; // level, held like a real flag group
      end
   end
endmodule // ifb_event_src

// file: test/ifb_bank_tb.sv
// ifb_bank_tb: self-checking bench for the flag and enable bank.
// assumes the apb slave answers in its own time; sources are modelled.
`timescale 1ns/1ps
module ifb_bank_tb;
   import ifb_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        fire, err;
   logic [1:0]  sel;
   logic [11:0] paddr;
   logic [3:0]  pstrb;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] bits, s5, s6, s7, g0, q5, q6, q7, q0, en0;
   logic [11:0] offs [4];
   logic [15:0] msk [4];
   int          fail_count, checked;

   ifb_bank i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .set_five(s5), .set_six(s6), .set_seven(s7), .group0_flags(g0),
      .request_five(q5), .request_six(q6), .request_seven(q7),
      .request_zero(q0), .enable_zero(en0));
   ifb_event_src i_src (.pclk(pclk), .fire(fire), .sel(sel), .bits(bits),
      .set_five(s5), .set_six(s6), .set_seven(s7), .group0_flags(g0));

   // =====================================================================
   // shared helpers
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one apb transfer; waits a full edge first so no signal is set twice
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= 4'h3;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 40);
      rd  = prdata;
      err = pslverr;
      if (n >= 40) begin
         fail_count++;
         tally_and_finish();
      end
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic event_in(input logic [1:0] s, input logic [15:0] b);
      @(posedge pclk);
      fire <= 1'b1;
      sel  <= s;
      bits <= b;
      @(posedge pclk);
      fire <= 1'b0;
      repeat (4) @(posedge pclk); // pulse, flag, then request copy
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // =====================================================================
   // clock, watchdog and test sequence
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   initial begin
      #40000;
      fail_count++;
      tally_and_finish();
   end
   initial begin
      fail_count = 0;
      checked = 0;
      {presetn, psel, penable, pwrite, fire} = 5'h00;
      {paddr, pwdata, pstrb, sel, bits} = '0;
      offs = '{OFF_FLAG_STATUS_FIVE, OFF_FLAG_STATUS_SIX,
               OFF_FLAG_STATUS_SEVEN, OFF_ENABLE_CONTROL_ZERO};
      msk = '{MASK_FIVE, MASK_SIX, MASK_SEVEN, MASK_EN0};
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, offs[i], 32'h0);
         check(rd, 32'h0);
      end
      $display("test reset values done");
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, offs[i], 32'hffffffff);
         apb(1'b0, offs[i], 32'h0);
         check(rd, {16'h0, msk[i]});
         apb(1'b1, offs[i], 32'h0);
         apb(1'b0, offs[i], 32'h0);
         check(rd, 32'h0);
      end
      $display("test bit map done");
      for (int i = 0; i < 3; i++) begin
         event_in(i[1:0], 16'hffff);
         apb(1'b0, offs[i], 32'h0);
         check(rd, {16'h0000, msk[i]});
      end
      check(q5, 16'hc000);
      check(q6, 16'hc383);
      check(q7, 16'h001f);
      $display("test events done");
      apb(1'b1, OFF_ENABLE_CONTROL_ZERO, 32'h0000ffff);
      event_in(2'd3, 16'hffff);
      check(en0, 16'h3fef);
      check(q0, 16'h3fef);
      apb(1'b0, OFF_REQUEST_STATUS, 32'h0);
      check(rd, 32'h00003fef);
      apb(1'b1, OFF_ENABLE_CONTROL_ZERO, 32'h00000001);
      repeat (3) @(posedge pclk);
      check(q0, 16'h0001);
      $display("test gating done");
      apb(1'b0, 12'h020, 32'h0);
      check(err, 1'b1);
      check(rd, 32'h0);
      $display("test unmapped done");
      tally_and_finish();
   end
endmodule // ifb_bank_tb
